// ---- hw/fpec_regs.svh ----
// fpec_regs.svh: offsets, bit positions, reset values and block map constants
// assumes: included by bare name ahead of modules that need the register map
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH

// APB byte offsets of the register words
`define FPEC_OFF_MODE 12'h000
`define FPEC_OFF_SETUP 12'h004
`define FPEC_OFF_EBHI 12'h008
`define FPEC_OFF_EBLO 12'h00C
`define FPEC_OFF_SYS 12'h010
`define FPEC_OFF_RAMER 12'h014

// mode control bits
`define FPEC_MC_PIN 7
`define FPEC_MC_SWE 6
`define FPEC_MC_EV 3
`define FPEC_MC_PV 2
`define FPEC_MC_E 1
`define FPEC_MC_P 0

// setup and error bits
`define FPEC_SE_ERR 7
`define FPEC_SE_ESU 1
`define FPEC_SE_PSU 0

// system control bits
`define FPEC_SYS_SEL 3
`define FPEC_RAMER_RAM_EMULATION_SELECT 2

// reset and fixed values
`define FPEC_BYTE_ZERO 8'h00
`define FPEC_WORD_ZERO 32'h00000000
`define FPEC_MODE_PIN_HI 8'h80
`define FPEC_BLOCKS 10
`define FPEC_BLK_ZERO 10'h000
`define FPEC_EBHI_MASK 8'h03

// flash byte address width and block base addresses
`define FPEC_FADDR_W 17
`define FPEC_BLK_BASES {17'h18000, 17'h10000, 17'h0E000, 17'h0C000, 17'h08000, \
                        17'h01000, 17'h00C00, 17'h00800, 17'h00400, 17'h00000}
`define FPEC_FLASH_END 17'h1FFFF

`endif

// ---- hw/fpec_pkg.sv ----
// fpec_pkg.sv: types shared by the flash program/erase control block
// assumes: compiled before the design modules
package fpec_pkg;

  // operating state reported to the flash array
  typedef enum logic [2:0] {
    FPEC_IDLE,
    FPEC_PROG,
    FPEC_ERASE,
    FPEC_PVERIFY,
    FPEC_EVERIFY
  } fpec_op_t;

endpackage

// ---- hw/fpec_block_decode.sv ----
// fpec_block_decode.sv: maps a flash byte address to its erase block
// assumes: combinational, used by the control block to gate erasure
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"

module fpec_block_decode
  import fpec_pkg::*;
(
  // address in
  input wire logic [`FPEC_FADDR_W-1:0] addr,
  // one-hot block out
  output logic [`FPEC_BLOCKS-1:0] block_hit
);

  localparam logic [`FPEC_BLOCKS*`FPEC_FADDR_W-1:0] BASES = `FPEC_BLK_BASES;

  // each block owns the range from its base to the next base; the last block runs to the flash end
  genvar g;
  generate
    for (g = 0; g < `FPEC_BLOCKS; g = g + 1) begin : g_blk
      if (g == `FPEC_BLOCKS - 1) begin : g_last
        assign block_hit[g] = (addr >= BASES[g*`FPEC_FADDR_W +: `FPEC_FADDR_W]) &&
                              (addr <= `FPEC_FLASH_END); // RULE_19
      end else begin : g_mid
        assign block_hit[g] = (addr >= BASES[g*`FPEC_FADDR_W +: `FPEC_FADDR_W]) &&
                              (addr < BASES[(g+1)*`FPEC_FADDR_W +: `FPEC_FADDR_W]); // RULE_19
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- hw/fpec_ctrl.sv ----
// fpec_ctrl.sv: flash program/erase control registers on APB
// assumes: one clock pclk, async active-low presetn, pins synchronous to pclk
//
// Operation
// RULE_01: verify modes may be entered once write enable set with pin high.
// RULE_02: program needs write enable, then program setup, then program start.
// RULE_03: erase needs write enable, then erase setup, then erase start.
// RULE_04: mode register reset by reset and standbys; reads 80 or 00 per pin.
// RULE_05: with flash disabled all registers read zero and ignore writes; code still reads and writes the system control and ramer registers.
// RULE_06: enable needs pin; verify needs enable; starts need their setup bit.
// RULE_07: mode bit 7 is read-only mirror of the protect pin.
// RULE_08: mode bit 6 is software write enable, reset to zero.
// RULE_09: software sets write enable first and never clears it together.
// RULE_10: mode bits 5 and 4 always read zero.
// RULE_11: bits 3..0 request erase-verify, program-verify, erase, program.
// RULE_12: software sets at most one control bit per write.
// RULE_13: setup register resets; setup bits also clear in standby and protect.
// RULE_14: setup bit 7 is read-only error flag, cleared only by reset; code also clears it in hardware standby.
// RULE_15: setup bits 6..2 read zero; setup bits need pin and enable.
// RULE_16: software sets setup before the matching start bit.
// RULE_17: block bits 9,8 in high register low bits; 7..0 in low register.
// RULE_18: block registers clear on reset, standby, pin low, or enable low.
// RULE_19: a set block bit makes only that block erasable.
// RULE_20: software selects one block at a time and erases in sequence.
// RULE_21: a gated bit write refused leaves that bit, others still update.
// RULE_22: flash registers reachable only while register select is one.
// RULE_23: while RAM emulation is selected every block is protected.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"

module fpec_ctrl
  import fpec_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins and status
  input wire logic hw_write_protect_pin,
  input wire logic flash_disabled,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic error_event,
  // flash array side
  input wire logic [`FPEC_FADDR_W-1:0] flash_addr,
  output fpec_op_t flash_op,
  output logic erase_allowed,
  output logic program_allowed,
  output logic error_protect
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic swe_q;
  logic [3:0] mode_q; // ev, pv, e, p
  logic esu_q;
  logic psu_q;
  logic err_q;
  logic [`FPEC_BLOCKS-1:0] blk_q;
  logic sel_q;
  logic ram_emulation_select_q;
  logic [`FPEC_BLOCKS-1:0] blk_hit;
  fpec_op_t op_d;
  fpec_op_t op_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit_mode;
  logic hit_setup;
  logic hit_ebhi;
  logic hit_eblo;
  logic hit_sys;
  logic hit_ramer;
  logic flash_hit;
  logic [7:0] wb;

  // zero-wait slave
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & pstrb[0];
  assign rd_en = psel & penable & ~pwrite;
  assign wb = pwdata[7:0];

  always_comb begin
    hit_mode = 1'b0;
    hit_setup = 1'b0;
    hit_ebhi = 1'b0;
    hit_eblo = 1'b0;
    hit_sys = 1'b0;
    hit_ramer = 1'b0;
    if (paddr == `FPEC_OFF_MODE) begin
      hit_mode = 1'b1;
    end else if (paddr == `FPEC_OFF_SETUP) begin
      hit_setup = 1'b1;
    end else if (paddr == `FPEC_OFF_EBHI) begin
      hit_ebhi = 1'b1;
    end else if (paddr == `FPEC_OFF_EBLO) begin
      hit_eblo = 1'b1;
    end else if (paddr == `FPEC_OFF_SYS) begin
      hit_sys = 1'b1;
    end else if (paddr == `FPEC_OFF_RAMER) begin
      hit_ramer = 1'b1;
    end
  end

  // flash registers error without select; unmapped offsets always error
  assign flash_hit = hit_mode | hit_setup | hit_ebhi | hit_eblo;
  assign pslverr = psel & penable & ((flash_hit & ~sel_q) |
                   ~(flash_hit | hit_sys | hit_ramer)); // RULE_22

  // write strobes per register, refused while deselected or disabled
  logic wr_mode;
  logic wr_setup;
  logic wr_ebhi;
  logic wr_eblo;
  assign wr_mode = wr_en & hit_mode & sel_q & ~flash_disabled; // RULE_05 RULE_22
  assign wr_setup = wr_en & hit_setup & sel_q & ~flash_disabled; // RULE_05 RULE_22
  assign wr_ebhi = wr_en & hit_ebhi & sel_q & ~flash_disabled; // RULE_05 RULE_22
  assign wr_eblo = wr_en & hit_eblo & sel_q & ~flash_disabled; // RULE_05 RULE_22

  // common reinitialisation: hardware or software standby
  logic standby;
  assign standby = hw_standby | sw_standby;

  // ----------------------------------------------------------------
  // system control and emulation select
  // ----------------------------------------------------------------
  // register select and ram emulation, reset by hardware standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 1'b0;
      ram_emulation_select_q <= 1'b0;
    end else if (hw_standby) begin
      sel_q <= 1'b0;
      ram_emulation_select_q <= 1'b0;
    end else begin
      if (wr_en && hit_sys) begin
        sel_q <= wb[`FPEC_SYS_SEL];
      end
      if (wr_en && hit_ramer) begin
        ram_emulation_select_q <= wb[`FPEC_RAMER_RAM_EMULATION_SELECT];
      end
    end
  end

  // ----------------------------------------------------------------
  // mode control register
  // ----------------------------------------------------------------
  // write enable gated by pin; cleared by reset and standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swe_q <= 1'b0; // RULE_08
    end else if (standby) begin
      swe_q <= 1'b0; // RULE_04
    end else if (wr_mode && hw_write_protect_pin) begin
      swe_q <= wb[`FPEC_MC_SWE]; // RULE_06 RULE_21
    end
  end

  // mode bits; erase and program each with its own setting condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 4'h0; // RULE_11
    end else if (standby || !hw_write_protect_pin || !swe_q) begin
      mode_q <= 4'h0; // RULE_04
    end else if (wr_mode) begin
      mode_q[3] <= wb[`FPEC_MC_EV]; // RULE_01 RULE_06
      mode_q[2] <= wb[`FPEC_MC_PV]; // RULE_01 RULE_06
      if (esu_q || !wb[`FPEC_MC_E]) begin
        mode_q[1] <= wb[`FPEC_MC_E]; // RULE_03 RULE_06 RULE_21
      end
      if (psu_q || !wb[`FPEC_MC_P]) begin
        mode_q[0] <= wb[`FPEC_MC_P]; // RULE_02 RULE_06 RULE_21
      end
    end
  end

  // ----------------------------------------------------------------
  // setup and error register
  // ----------------------------------------------------------------
  // setup bits clear in standby and in hardware/software protect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esu_q <= 1'b0;
      psu_q <= 1'b0;
    end else if (standby || !hw_write_protect_pin || !swe_q) begin
      esu_q <= 1'b0; // RULE_13
      psu_q <= 1'b0; // RULE_13
    end else if (wr_setup) begin
      esu_q <= wb[`FPEC_SE_ESU]; // RULE_15
      psu_q <= wb[`FPEC_SE_PSU]; // RULE_15
    end
  end

  // error flag, sticky until reset or hardware standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (hw_standby) begin
      err_q <= 1'b0; // RULE_14
    end else if (error_event && op_q != FPEC_IDLE) begin
      err_q <= 1'b1; // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // erase block registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_q <= `FPEC_BLK_ZERO;
    end else if (standby || !hw_write_protect_pin || !swe_q) begin
      blk_q <= `FPEC_BLK_ZERO; // RULE_18
    end else begin
      if (wr_ebhi) begin
        blk_q[9:8] <= wb[1:0]; // RULE_17
      end
      if (wr_eblo) begin
        blk_q[7:0] <= wb; // RULE_17
      end
    end
  end

  // ----------------------------------------------------------------
  // operation state toward the array
  // ----------------------------------------------------------------
  fpec_block_decode u_decode (
    .addr(flash_addr),
    .block_hit(blk_hit)
  );

  // program wins over verify when both requested
  always_comb begin
    op_d = FPEC_IDLE;
    if (mode_q[0]) begin
      op_d = FPEC_PROG; // RULE_02
    end else if (mode_q[1]) begin
      op_d = FPEC_ERASE; // RULE_03
    end else if (mode_q[2]) begin
      op_d = FPEC_PVERIFY; // RULE_01
    end else if (mode_q[3]) begin
      op_d = FPEC_EVERIFY; // RULE_01
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= FPEC_IDLE;
    end else begin
      op_q <= op_d;
    end
  end

  assign flash_op = op_q;
  assign error_protect = err_q;
  assign program_allowed = (op_q == FPEC_PROG) & ~err_q & ~ram_emulation_select_q; // RULE_23
  assign erase_allowed = (op_q == FPEC_ERASE) & ~err_q & ~ram_emulation_select_q &
                         |(blk_hit & blk_q); // RULE_19 RULE_23

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rb;
  always_comb begin
    rb = `FPEC_BYTE_ZERO;
    if (hit_sys) begin
      rb[`FPEC_SYS_SEL] = sel_q;
    end else if (hit_ramer) begin
      rb[`FPEC_RAMER_RAM_EMULATION_SELECT] = ram_emulation_select_q;
    end else if (flash_disabled || !sel_q) begin
      rb = `FPEC_BYTE_ZERO; // RULE_05
    end else if (hit_mode) begin
      rb = {hw_write_protect_pin, swe_q, 2'b00, mode_q}; // RULE_07 RULE_10
    end else if (hit_setup) begin
      rb = {err_q, 5'h00, esu_q, psu_q}; // RULE_14 RULE_15
    end else if (hit_ebhi) begin
      rb = {6'h00, blk_q[9:8]}; // RULE_17
    end else if (hit_eblo) begin
      rb = blk_q[7:0]; // RULE_17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `FPEC_WORD_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rb};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pin_mirror: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    rd_en && hit_mode && sel_q && !flash_disabled && $stable(hw_write_protect_pin)
    |-> prdata[7] == hw_write_protect_pin) else $error("pin mirror wrong");
  a_swe_needs_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    $rose(swe_q) |-> $past(hw_write_protect_pin)) else $error("swe set without pin");
  a_prog_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    $rose(mode_q[0]) |-> $past(psu_q) && $past(swe_q)) else $error("program without setup");
  a_erase_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    $rose(mode_q[1]) |-> $past(esu_q) && $past(swe_q)) else $error("erase without setup");
  a_verify_swe: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    $rose(mode_q[3]) || $rose(mode_q[2]) |-> $past(swe_q)) else $error("verify without swe");
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    err_q && !hw_standby |=> err_q) else $error("error flag lost");
  a_blk_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    !swe_q |=> blk_q == `FPEC_BLK_ZERO) else $error("blocks not cleared");
  a_disabled_rd: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    psel && !penable && !pwrite && flash_hit && flash_disabled |=> prdata == `FPEC_WORD_ZERO)
    else $error("disabled read not zero");
  a_ram_emulation_select_protect: assert property (@(posedge pclk) disable iff (!presetn) // RULE_23
    ram_emulation_select_q |-> !erase_allowed && !program_allowed) else $error("emulation not protected");
  a_setup_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    !hw_write_protect_pin |=> !esu_q && !psu_q) else $error("setup not cleared");

  // refusal, standby, error-set and pin-low block clear checks
  a_sel_refuse: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
    wr_en && hit_mode && !sel_q && !standby |=> $stable(swe_q))
    else $error("deselected write taken");
  a_swe_standby: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    standby |=> !swe_q && mode_q == 4'h0) else $error("standby left mode set");
  a_err_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    error_event && op_q != FPEC_IDLE && !hw_standby |=> err_q) else $error("error flag not set");
  a_blk_pin: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    !hw_write_protect_pin |=> blk_q == `FPEC_BLK_ZERO) else $error("blocks kept with pin low");

endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// tb.sv: self-checking bench for the flash program/erase control block
// assumes: fpec_pkg compiled first, fpec_regs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"

// ----------------------------------------
// compare helper
// ----------------------------------------
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, act, exp); end end

module tb
  import fpec_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic pin, fdis, hsb, ssb, err_ev, eall, pall, eprot, slverr;
  logic [`FPEC_FADDR_W-1:0] faddr;
  fpec_op_t fop;
  int bad_count, checked;

  // ----------------------------------------
  // device under test
  // ----------------------------------------
  fpec_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_write_protect_pin(pin), .flash_disabled(fdis), .hw_standby(hsb), .sw_standby(ssb),
    .error_event(err_ev), .flash_addr(faddr), .flash_op(fop), .erase_allowed(eall),
    .program_allowed(pall), .error_protect(eprot));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end else begin
      rdat = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdat, {24'h000000, e})
  endtask

  // let a mode write reach the registered operation output
  task automatic tick();
    repeat (2) @(negedge pclk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, fdis, hsb, ssb, err_ev} = '0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    pin = 1'b1;
    faddr = '0;
    bad_count = 0;
    checked = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // deselected registers answer with an error
    apb(1'b0, `FPEC_OFF_MODE, 8'h00);
    `CHK(slverr, 1'b1)
    wr(`FPEC_OFF_MODE, 8'h40);
    `CHK(slverr, 1'b1)
    wr(`FPEC_OFF_SYS, 8'h08);
    rd(`FPEC_OFF_MODE, 8'h80);
    rd(`FPEC_OFF_SETUP, 8'h00);
    rd(`FPEC_OFF_EBHI, 8'h00);
    rd(`FPEC_OFF_EBLO, 8'h00);
    apb(1'b0, 12'h018, 8'h00);
    `CHK(slverr, 1'b1)
    // flash disabled: reads zero, writes lost
    @(posedge pclk) fdis <= 1'b1;
    wr(`FPEC_OFF_MODE, 8'h40);
    rd(`FPEC_OFF_MODE, 8'h00);
    @(posedge pclk) fdis <= 1'b0;
    rd(`FPEC_OFF_MODE, 8'h80);
    // enable refused while pin low
    @(posedge pclk) pin <= 1'b0;
    wr(`FPEC_OFF_MODE, 8'h40);
    rd(`FPEC_OFF_MODE, 8'h00);
    @(posedge pclk) pin <= 1'b1;
    wr(`FPEC_OFF_MODE, 8'h70);
    rd(`FPEC_OFF_MODE, 8'hC0);
    // program start refused without setup, enable kept
    wr(`FPEC_OFF_MODE, 8'h41);
    rd(`FPEC_OFF_MODE, 8'hC0);
    wr(`FPEC_OFF_SETUP, 8'hFD);
    rd(`FPEC_OFF_SETUP, 8'h01);
    wr(`FPEC_OFF_MODE, 8'h41);
    rd(`FPEC_OFF_MODE, 8'hC1);
    tick();
    `CHK(fop, FPEC_PROG)
    `CHK(pall, 1'b1)
    // erase of block 0 only
    wr(`FPEC_OFF_MODE, 8'h40);
    wr(`FPEC_OFF_SETUP, 8'h02);
    wr(`FPEC_OFF_EBHI, 8'hFF);
    rd(`FPEC_OFF_EBHI, 8'h03);
    wr(`FPEC_OFF_EBHI, 8'h00);
    wr(`FPEC_OFF_EBLO, 8'h01);
    wr(`FPEC_OFF_MODE, 8'h42);
    tick();
    `CHK(fop, FPEC_ERASE)
    `CHK(eall, 1'b1)
    @(posedge pclk) faddr <= 17'h00400;
    @(negedge pclk);
    `CHK(eall, 1'b0)
    @(posedge pclk) faddr <= 17'h003FF;
    wr(`FPEC_OFF_RAMER, 8'h04);
    @(negedge pclk);
    `CHK(eall, 1'b0)
    wr(`FPEC_OFF_RAMER, 8'h00);
    @(negedge pclk);
    `CHK(eall, 1'b1)
    // error during erase
    @(posedge pclk) err_ev <= 1'b1;
    @(posedge pclk) err_ev <= 1'b0;
    rd(`FPEC_OFF_SETUP, 8'h82);
    `CHK(eprot, 1'b1)
    `CHK(eall, 1'b0)
    // software standby keeps the error flag
    @(posedge pclk) ssb <= 1'b1;
    @(posedge pclk) ssb <= 1'b0;
    rd(`FPEC_OFF_MODE, 8'h80);
    rd(`FPEC_OFF_SETUP, 8'h80);
    rd(`FPEC_OFF_EBLO, 8'h00);
    // verify modes
    wr(`FPEC_OFF_MODE, 8'h40);
    wr(`FPEC_OFF_MODE, 8'h48);
    tick();
    `CHK(fop, FPEC_EVERIFY)
    wr(`FPEC_OFF_MODE, 8'h44);
    tick();
    `CHK(fop, FPEC_PVERIFY)
    // pin low clears block select and modes
    wr(`FPEC_OFF_EBLO, 8'h80);
    rd(`FPEC_OFF_EBLO, 8'h80);
    @(posedge pclk) pin <= 1'b0;
    rd(`FPEC_OFF_EBLO, 8'h00);
    rd(`FPEC_OFF_MODE, 8'h40);
    `CHK(fop, FPEC_IDLE)
    // hardware standby clears the error flag
    @(posedge pclk) hsb <= 1'b1;
    @(posedge pclk) hsb <= 1'b0;
    wr(`FPEC_OFF_SYS, 8'h08);
    rd(`FPEC_OFF_SETUP, 8'h00);
    results();
  end
endmodule
`default_nettype wire
